//--- design/scbp_config_port.sv
// smbus target giving indexed block access to the clock buffer config bytes
// assumes scl is the link clock, sda is open drain, core clk is unrelated
//
// Summary of operation
// - acknowledge own write address, the index byte and the count byte.
// - acknowledge each data byte, storing into indexes N through N+X-1.
// - after acknowledging read address, send the byte count first.
// - then return contents from index N onward; the host nack sets the length.
// - target address comes from address-select pin, latched once, not followed.
// - byte 0 holds enables of outputs 5..0 at bits 7,6,4,3,2,0; reset 1.
// - cleared enable overrides the enable pin; output goes to disable state.
// - byte 1 bit 5 enables output 6, reset 1, same override.
// - byte 1 bits 1:0 pick output amplitude, reset 10.
// - slew selects in byte 2 and byte 3 bit 0; 1 fast, reset fast.
// - byte 4 is reserved and reads all ones.
// - byte 5 is read-only revision and maker codes.
`timescale 1ns/100ps
module scbp_config_port
   import scbp_pkg::*;
#(
   parameter logic [3:0] REV_CODE = 4'h2, // arbitrary value
   parameter logic [3:0] MAKER_CODE = 4'hA // arbitrary value
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sclClk,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [1:0] addrSelLevel,
   input wire logic [6:0] oePinsN,
   output logic [6:0] outRun,
   output logic [1:0] outStopState,
   output logic [6:0] outSlewFast,
   output logic [1:0] outAmplitude,
   output logic [6:0] targetAddr,
   output logic addrLocked
);

   // start detector: toggles on falling sda while scl is high
   logic startTgl_r;
   logic startTgl_nxt;

   always_comb begin
      startTgl_nxt = sclClk ? ~startTgl_r : startTgl_r;
   end

   always_ff @(negedge sdaIn or posedge sys_rst) begin
      if (sys_rst) begin
         startTgl_r <= 1'b0;
      end else begin
         startTgl_r <= startTgl_nxt;
      end
   end

   // link side state, clocked by scl; reset is asynchronous while scl is idle
   scbp_link_e state_r, state_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] idx_r, idx_nxt;
   logic [7:0] remain_r, remain_nxt;
   logic [7:0] txByte_r, txByte_nxt;
   logic [7:0] count_r, count_nxt;
   logic rw_r, rw_nxt;
   logic startAck_r, startAck_nxt;
   logic cfgTgl_r, cfgTgl_nxt;
   scbp_cfg_s cfg_r, cfg_nxt;
   logic sdaOe_r, sdaOe_nxt;
   logic startPend;
   logic [7:0] rxByte;
   logic [7:0] readByte;
   logic lockedLink;
   logic [6:0] addrCode_r, addrCode_nxt;

   assign startPend = startTgl_r != startAck_r;
   assign rxByte = {shift_r[6:0], sdaIn};

   // read mux; unmapped indexes read as zero
   always_comb begin
      case (idx_r)
         IDX_EN_LOW: readByte = cfg_r.enLow;
         IDX_EN_AMP: readByte = cfg_r.enAmp;
         IDX_SLEW_LOW: readByte = cfg_r.slewLow;
         IDX_SLEW_HIGH: readByte = cfg_r.slewHigh;
         IDX_RSVD: readByte = RSVD_VALUE;
         IDX_REV_MAKER: readByte = {REV_CODE, MAKER_CODE};
         IDX_BYTE_COUNT: readByte = count_r;
         default: readByte = UNMAPPED_VALUE;
      endcase
   end

   // byte-level protocol engine
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r + BIT_SECOND;
      shift_nxt = rxByte;
      idx_nxt = idx_r;
      remain_nxt = remain_r;
      txByte_nxt = txByte_r;
      count_nxt = count_r;
      rw_nxt = rw_r;
      startAck_nxt = startTgl_r;
      cfgTgl_nxt = cfgTgl_r;
      cfg_nxt = cfg_r;
      if (startPend) begin
         // index survives a repeated start so a read picks it up
         state_nxt = LK_ADDR;
         bitCnt_nxt = BIT_SECOND;
      end else begin
         case (state_r)
            LK_IDLE: begin
               bitCnt_nxt = BIT_FIRST;
            end
            LK_ADDR: begin
               if (bitCnt_r == BIT_LAST) begin
                  rw_nxt = rxByte[0];
                  // only a matching latched address gets an ack
                  if (lockedLink && rxByte[7:1] == addrCode_r) begin
                     state_nxt = LK_ADDR_ACK;
                  end else begin
                     state_nxt = LK_IDLE;
                  end
               end
            end
            LK_ADDR_ACK: begin
               bitCnt_nxt = BIT_FIRST;
               if (rw_r) begin
                  state_nxt = LK_RDATA;
                  txByte_nxt = count_r;
               end else begin
                  state_nxt = LK_INDEX;
               end
            end
            LK_INDEX: begin
               if (bitCnt_r == BIT_LAST) begin
                  idx_nxt = rxByte;
                  state_nxt = LK_INDEX_ACK;
               end
            end
            LK_INDEX_ACK: begin
               bitCnt_nxt = BIT_FIRST;
               state_nxt = LK_COUNT;
            end
            LK_COUNT: begin
               if (bitCnt_r == BIT_LAST) begin
                  remain_nxt = rxByte;
                  state_nxt = LK_COUNT_ACK;
               end
            end
            LK_COUNT_ACK, LK_WDATA_ACK: begin
               bitCnt_nxt = BIT_FIRST;
               state_nxt = LK_WDATA;
            end
            LK_WDATA: begin
               if (bitCnt_r == BIT_LAST) begin
                  state_nxt = LK_WDATA_ACK;
                  // bytes past the count are acked but dropped
                  if (remain_r != UNMAPPED_VALUE) begin
                     remain_nxt = remain_r - IDX_STEP;
                     idx_nxt = idx_r + IDX_STEP;
                     cfgTgl_nxt = ~cfgTgl_r;
                     // masked merge keeps reserved and read-only bits
                     case (idx_r)
                        IDX_EN_LOW: cfg_nxt.enLow = scbp_merge(cfg_r.enLow, rxByte, MSK_EN_LOW);
                        IDX_EN_AMP: cfg_nxt.enAmp = scbp_merge(cfg_r.enAmp, rxByte, MSK_EN_AMP);
                        IDX_SLEW_LOW: begin
                           cfg_nxt.slewLow = scbp_merge(cfg_r.slewLow, rxByte, MSK_SLEW_LOW);
                        end
                        IDX_SLEW_HIGH: begin
                           cfg_nxt.slewHigh = scbp_merge(cfg_r.slewHigh, rxByte, MSK_SLEW_HIGH);
                        end
                        IDX_BYTE_COUNT: count_nxt = scbp_merge(count_r, rxByte, MSK_BYTE_COUNT);
                        default: cfg_nxt = cfg_r;
                     endcase
                  end
               end
            end
            LK_RDATA: begin
               if (bitCnt_r == BIT_LAST) begin
                  state_nxt = LK_RDATA_ACK;
               end
            end
            LK_RDATA_ACK: begin
               bitCnt_nxt = BIT_FIRST;
               // host ack asks for the next index, nack ends the read
               if (!sdaIn) begin
                  txByte_nxt = readByte;
                  idx_nxt = idx_r + IDX_STEP;
                  state_nxt = LK_RDATA;
               end else begin
                  state_nxt = LK_IDLE;
               end
            end
            default: state_nxt = LK_IDLE;
         endcase
      end
   end

   always_ff @(posedge sclClk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= LK_IDLE;
         bitCnt_r <= BIT_FIRST;
         shift_r <= UNMAPPED_VALUE;
         idx_r <= UNMAPPED_VALUE;
         remain_r <= UNMAPPED_VALUE;
         txByte_r <= UNMAPPED_VALUE;
         count_r <= RST_BYTE_COUNT;
         rw_r <= 1'b0;
         startAck_r <= 1'b0;
         cfgTgl_r <= 1'b0;
         cfg_r <= CFG_RESET;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         idx_r <= idx_nxt;
         remain_r <= remain_nxt;
         txByte_r <= txByte_nxt;
         count_r <= count_nxt;
         rw_r <= rw_nxt;
         startAck_r <= startAck_nxt;
         cfgTgl_r <= cfgTgl_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // sda changes only while scl is low, so drive on the falling edge
   always_comb begin
      case (state_r)
         LK_ADDR_ACK, LK_INDEX_ACK, LK_COUNT_ACK, LK_WDATA_ACK: sdaOe_nxt = 1'b1;
         LK_RDATA: sdaOe_nxt = ~txByte_r[~bitCnt_r]; // msb first, pull low for a zero
         default: sdaOe_nxt = 1'b0;
      endcase
   end

   always_ff @(negedge sclClk or posedge sys_rst) begin
      if (sys_rst) begin
         sdaOe_r <= 1'b0;
      end else begin
         sdaOe_r <= sdaOe_nxt;
      end
   end

   assign sdaOe = sdaOe_r;
   assign sdaOut = 1'b0;

   // core side: pins and the config toggle cross through two flops
   logic [9:0] coreSync;
   logic [6:0] oeSyncN;
   logic [1:0] selSync;
   logic cfgTglSync;

   scbp_sync #(.WIDTH(10)) u_core_sync (
      .clk(clk),
      .rst(sys_rst),
      .d({cfgTgl_r, addrSelLevel, oePinsN}),
      .q(coreSync)
   );
   assign {cfgTglSync, selSync, oeSyncN} = coreSync;

   logic addrLocked_r, addrLocked_nxt;

   // lock level reaches the link; the code is static before it rises
   scbp_sync #(.WIDTH(1)) u_link_sync (
      .clk(sclClk),
      .rst(sys_rst),
      .d(addrLocked_r),
      .q(lockedLink)
   );

   logic [1:0] settle_r, settle_nxt;
   logic tglSeen_r, tglSeen_nxt;
   scbp_cfg_s cfgCore_r, cfgCore_nxt;
   logic [6:0] run_r, run_nxt;
   logic [6:0] slew_r, slew_nxt;
   logic [1:0] amp_r, amp_nxt;
   logic [1:0] stop_r, stop_nxt;
   logic [6:0] enVec;
   logic [6:0] slewVec;

   // per-output field extraction
   genvar g;
   generate
      for (g = 0; g < LOW_GROUP; g++) begin : g_out
         assign enVec[g] = cfgCore_r.enLow[GROUP_POS[g]];
         assign slewVec[g] = cfgCore_r.slewLow[GROUP_POS[g]];
      end
   endgenerate
   assign enVec[LOW_GROUP] = cfgCore_r.enAmp[OUT6_EN_POS];
   assign slewVec[LOW_GROUP] = cfgCore_r.slewHigh[OUT6_SLEW_POS];

   // address latch after the pin has settled, config capture on toggle
   always_comb begin
      addrLocked_nxt = addrLocked_r;
      settle_nxt = settle_r;
      addrCode_nxt = addrCode_r;
      if (!addrLocked_r) begin
         if (settle_r == SETTLE_CYCLES) begin
            // latched once and never followed afterwards
            addrLocked_nxt = 1'b1;
            case (selSync)
               SEL_LOW: addrCode_nxt = ADDR_LOW;
               SEL_MID: addrCode_nxt = ADDR_MID;
               default: addrCode_nxt = ADDR_HIGH;
            endcase
         end else begin
            settle_nxt = settle_r + SETTLE_STEP;
         end
      end
      tglSeen_nxt = cfgTglSync;
      // link config is held stable for many scl cycles after a toggle
      cfgCore_nxt = (cfgTglSync != tglSeen_r) ? cfg_r : cfgCore_r;
      run_nxt = enVec & ~oeSyncN; // cleared bit overrides the pin
      slew_nxt = slewVec;
      amp_nxt = cfgCore_r.enAmp[AMP_MSB:AMP_LSB];
      stop_nxt = DISABLE_STATE_DEFAULT;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         addrLocked_r <= 1'b0;
         settle_r <= '0;
         addrCode_r <= ADDR_LOW;
         tglSeen_r <= 1'b0;
         cfgCore_r <= CFG_RESET;
         run_r <= '0;
         slew_r <= '0;
         amp_r <= '0;
         stop_r <= DISABLE_STATE_DEFAULT;
      end else begin
         addrLocked_r <= addrLocked_nxt;
         settle_r <= settle_nxt;
         addrCode_r <= addrCode_nxt;
         tglSeen_r <= tglSeen_nxt;
         cfgCore_r <= cfgCore_nxt;
         run_r <= run_nxt;
         slew_r <= slew_nxt;
         amp_r <= amp_nxt;
         stop_r <= stop_nxt;
      end
   end

   assign outRun = run_r;
   assign outSlewFast = slew_r;
   assign outAmplitude = amp_r;
   assign outStopState = stop_r;
   assign targetAddr = addrCode_r;
   assign addrLocked = addrLocked_r;

   // checks on the link side
   a_addr_ack: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_ADDR_ACK || state_r == LK_INDEX_ACK || state_r == LK_COUNT_ACK) |-> sdaOe_r)
      else $error("header byte not acknowledged");
   a_data_ack: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_WDATA_ACK) |-> sdaOe_r)
      else $error("write data byte not acknowledged");
   a_write_step: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_WDATA && bitCnt_r == BIT_LAST && remain_r != UNMAPPED_VALUE && !startPend)
      |=> (idx_r == $past(idx_r) + IDX_STEP) && (cfgTgl_r != $past(cfgTgl_r)))
      else $error("write did not advance index");
   a_write_drop: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_WDATA && remain_r == UNMAPPED_VALUE) |=> $stable(cfg_r) && $stable(count_r))
      else $error("byte beyond count was stored");
   a_count_first: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_ADDR_ACK && rw_r && !startPend)
      |=> (txByte_r == $past(count_r)) && (state_r == LK_RDATA) ##1 sdaOe_r == ~txByte_r[BIT_LAST])
      else $error("count byte not sent first");
   a_read_next: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_RDATA_ACK && !sdaIn && !startPend)
      |=> (txByte_r == $past(readByte)) && (idx_r == $past(idx_r) + IDX_STEP))
      else $error("wrong read byte or index");
   a_nack_end: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_RDATA_ACK && sdaIn && !startPend) |=> state_r == LK_IDLE ##1 !sdaOe_r)
      else $error("read continued after nack");
   a_rsvd_read: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_RDATA_ACK && !sdaIn && !startPend && idx_r == IDX_RSVD)
      |=> txByte_r == RSVD_VALUE)
      else $error("reserved byte not all ones");
   a_rev_fixed: assert property (@(posedge sclClk) disable iff (sys_rst)
      (state_r == LK_RDATA_ACK && !sdaIn && !startPend && idx_r == IDX_REV_MAKER)
      |=> txByte_r == {REV_CODE, MAKER_CODE})
      else $error("revision byte changed");
   a_rsvd_bits: assert property (@(posedge sclClk) disable iff (sys_rst)
      (((cfg_r.enLow ^ RST_EN_LOW) & ~MSK_EN_LOW) == '0)
      && (((cfg_r.enAmp ^ RST_EN_AMP) & ~MSK_EN_AMP) == '0)
      && (((cfg_r.slewHigh ^ RST_SLEW_HIGH) & ~MSK_SLEW_HIGH) == '0))
      else $error("reserved bit was written");

   // checks on the core side
   a_oe_override: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> (run_r & ~$past(enVec)) == '0 && stop_r == DISABLE_STATE_DEFAULT)
      else $error("disabled output still running");
   a_addr_hold: assert property (@(posedge clk) disable iff (sys_rst)
      addrLocked_r |=> addrLocked_r && $stable(addrCode_r))
      else $error("target address followed the pin");
   a_addr_map: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(addrLocked_r) |-> addrCode_r == (($past(selSync) == SEL_LOW) ? ADDR_LOW :
         ($past(selSync) == SEL_MID) ? ADDR_MID : ADDR_HIGH))
      else $error("wrong target address for select level");

   c_write: cover property (@(posedge sclClk) disable iff (sys_rst)
      state_r == LK_WDATA_ACK && $changed(cfgTgl_r));
   c_read: cover property (@(posedge sclClk) disable iff (sys_rst)
      state_r == LK_RDATA_ACK && !sdaIn);
   c_nack: cover property (@(posedge sclClk) disable iff (sys_rst)
      state_r == LK_RDATA_ACK && sdaIn);
   c_override: cover property (@(posedge clk) disable iff (sys_rst)
      !enVec[0] && !oeSyncN[0]);
endmodule

//--- design/scbp_pkg.sv
// constants, types and helpers shared by the smbus clock buffer config port
// assumes an smbus host on the link and a core clock for the buffer controls
package scbp_pkg;

   // register indexes as seen on the link
   localparam logic [7:0] IDX_EN_LOW = 8'h00;
   localparam logic [7:0] IDX_EN_AMP = 8'h01;
   localparam logic [7:0] IDX_SLEW_LOW = 8'h02;
   localparam logic [7:0] IDX_SLEW_HIGH = 8'h03;
   localparam logic [7:0] IDX_RSVD = 8'h04;
   localparam logic [7:0] IDX_REV_MAKER = 8'h05;
   localparam logic [7:0] IDX_BYTE_COUNT = 8'h07;

   // reset values, reserved bits included
   localparam logic [7:0] RST_EN_LOW = 8'hDD;
   localparam logic [7:0] RST_EN_AMP = 8'h2E;
   localparam logic [7:0] RST_SLEW_LOW = 8'hDD;
   localparam logic [7:0] RST_SLEW_HIGH = 8'h47;
   localparam logic [7:0] RST_BYTE_COUNT = 8'h08;
   localparam logic [7:0] RSVD_VALUE = 8'hFF;
   localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

   // writable bits per register; the rest hold their reset value
   localparam logic [7:0] MSK_EN_LOW = 8'hDD;
   localparam logic [7:0] MSK_EN_AMP = 8'h23;
   localparam logic [7:0] MSK_SLEW_LOW = 8'hDD;
   localparam logic [7:0] MSK_SLEW_HIGH = 8'h01;
   localparam logic [7:0] MSK_BYTE_COUNT = 8'h1F;

   // field positions: outputs 0..5 share one layout, output 6 is apart
   localparam int NUM_OUT = 7;
   localparam int LOW_GROUP = 6;
   localparam int GROUP_POS [0:5] = '{0, 2, 3, 4, 6, 7};
   localparam int OUT6_EN_POS = 5;
   localparam int OUT6_SLEW_POS = 0;
   localparam int AMP_MSB = 1;
   localparam int AMP_LSB = 0;

   // disable state of a stopped output: both legs low
   localparam logic [1:0] DISABLE_STATE_DEFAULT = 2'b00;

   // target addresses per address-select level
   localparam logic [1:0] SEL_LOW = 2'b00;
   localparam logic [1:0] SEL_MID = 2'b01;
   localparam logic [6:0] ADDR_LOW = 7'h6B;
   localparam logic [6:0] ADDR_MID = 7'h6C;
   localparam logic [6:0] ADDR_HIGH = 7'h6D;

   // bit counter marks and address settle delay in core cycles
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_SECOND = 3'h1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;
   localparam logic [1:0] SETTLE_STEP = 2'h1;
   localparam logic [7:0] IDX_STEP = 8'h01;

   typedef enum logic [3:0] {
      LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_INDEX, LK_INDEX_ACK, LK_COUNT, LK_COUNT_ACK,
      LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RDATA_ACK
   } scbp_link_e;

   typedef struct packed {
      logic [7:0] enLow;
      logic [7:0] enAmp;
      logic [7:0] slewLow;
      logic [7:0] slewHigh;
   } scbp_cfg_s;

   localparam scbp_cfg_s CFG_RESET = '{RST_EN_LOW, RST_EN_AMP, RST_SLEW_LOW, RST_SLEW_HIGH};

   // keep unwritable bits, take writable ones from the host byte
   function automatic logic [7:0] scbp_merge(input logic [7:0] old, input logic [7:0] data,
                                             input logic [7:0] mask);
      scbp_merge = (old & ~mask) | (data & mask);
   endfunction

endpackage

//--- design/scbp_sync.sv
// two-flop synchroniser for a bundle of independent levels or a toggle
// assumes each bit is read only from q, never from the first stage
`timescale 1ns/100ps
module scbp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage1_nxt;

   // first stage only feeds the second
   always_comb begin
      stage1_nxt = d;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1_r <= '0;
         q <= '0;
      end else begin
         stage1_r <= stage1_nxt;
         q <= stage1_r;
      end
   end
endmodule

//--- bench/scbp_host_model.sv
// smbus host model driving the link clock and pulling the data wire low
// assumes the bench resolves the wire with a pull-up from both pull-downs
`timescale 1ns/100ps
module scbp_host_model (
   output logic sclClk,
   output logic pullLow,
   input wire logic sdaLine
);
   localparam time Q = 20ns;
   // link clock idles high between frames, wire released
   initial begin
      sclClk = 1'b1;
      pullLow = 1'b0;
   end
   // one bit: change data in the low phase, sample mid high phase
   task automatic bitSlot(input logic drv, output logic seen);
      sclClk = 1'b0;
      #(Q) pullLow = ~drv;
      #(Q) sclClk = 1'b1;
      #(Q) seen = sdaLine;
      #(Q);
   endtask
   // start and repeated start alike: data falls while clock high
   task automatic startCond();
      sclClk = 1'b0;
      #(Q) pullLow = 1'b0;
      #(Q) sclClk = 1'b1;
      #(Q) pullLow = 1'b1;
      #(Q);
   endtask
   // stop: data rises while clock high, clock then stands still
   task automatic stopCond();
      sclClk = 1'b0;
      #(Q) pullLow = 1'b1;
      #(Q) sclClk = 1'b1;
      #(Q) pullLow = 1'b0;
      #(Q);
   endtask
   // msb first, wire released on the ninth bit for the target ack
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(d[i], s);
      end
      bitSlot(1'b1, s);
      ack = ~s;
   endtask
   // host acks each byte, not-acknowledge on the last
   task automatic rdByte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(1'b1, d[i]);
      end
      bitSlot(last, s);
   endtask
endmodule

//--- bench/test_scbp_config_port.sv
// self-checking bench for the config port, host model on the link
// assumes default reset config and an address-select pin held low at the first reset
`timescale 1ns/100ps
module test_scbp_config_port;
   import scbp_pkg::*;
   logic clk, sys_rst, sclClk, pullLow, sdaOut, sdaOe, addrLocked;
   logic [1:0] addrSelLevel, outStopState, outAmplitude;
   logic [6:0] oePinsN, outRun, outSlewFast, targetAddr;
   wire logic sdaLine;
   int err_count = 0;
   int cmp_count = 0;
   // open-drain wire with pull-up
   assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~pullLow;
   scbp_config_port #(.REV_CODE(4'h3), .MAKER_CODE(4'h5)) scbp_config_port_inst (
      .clk(clk), .sys_rst(sys_rst), .sclClk(sclClk), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .addrSelLevel(addrSelLevel), .oePinsN(oePinsN), .outRun(outRun),
      .outStopState(outStopState), .outSlewFast(outSlewFast), .outAmplitude(outAmplitude),
      .targetAddr(targetAddr), .addrLocked(addrLocked));
   scbp_host_model scbp_host_model_inst (.sclClk(sclClk), .pullLow(pullLow), .sdaLine(sdaLine));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic sendExp(input logic [7:0] b, input logic expAck);
      logic a;
      scbp_host_model_inst.wrByte(b, a);
      check("ack", {7'h00, a}, {7'h00, expAck});
   endtask
   // core outputs settle within five clk cycles of a stored byte
   task automatic settle();
      repeat (8) @(negedge clk);
   endtask
   task automatic writeBlock(input logic [7:0] idx, input logic [7:0] dat [$]);
      scbp_host_model_inst.startCond();
      sendExp({ADDR_LOW, 1'b0}, 1'b1);
      sendExp(idx, 1'b1);
      sendExp(8'(dat.size()), 1'b1);
      foreach (dat[i]) sendExp(dat[i], 1'b1);
      scbp_host_model_inst.stopCond();
   endtask
   task automatic readBlock(input logic [7:0] idx, input logic [7:0] exp [$]);
      logic [7:0] d;
      scbp_host_model_inst.startCond();
      sendExp({ADDR_LOW, 1'b0}, 1'b1);
      sendExp(idx, 1'b1);
      scbp_host_model_inst.startCond();
      sendExp({ADDR_LOW, 1'b1}, 1'b1);
      scbp_host_model_inst.rdByte(1'b0, d);
      check("count byte", d, RST_BYTE_COUNT);
      foreach (exp[i]) begin
         scbp_host_model_inst.rdByte(i == exp.size() - 1, d);
         check("read byte", d, exp[i]);
      end
      scbp_host_model_inst.stopCond();
   endtask
   task automatic testReset();
      check("run", {1'b0, outRun}, 8'h7F);
      check("slew", {1'b0, outSlewFast}, 8'h7F);
      check("amplitude", {6'h00, outAmplitude}, 8'h02);
      check("stop state", {6'h00, outStopState}, 8'h00);
      check("address", {1'b0, targetAddr}, {1'b0, ADDR_LOW});
      readBlock(IDX_EN_LOW, '{RST_EN_LOW, RST_EN_AMP, RST_SLEW_LOW, RST_SLEW_HIGH, 8'hFF, 8'h35});
      $display("reset test done");
   endtask
   task automatic testWriteZero();
      writeBlock(IDX_EN_LOW, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      settle();
      check("run", {1'b0, outRun}, 8'h00);
      check("slew", {1'b0, outSlewFast}, 8'h00);
      check("amplitude", {6'h00, outAmplitude}, 8'h00);
      // reserved bits keep their reset value, bytes 4 and 5 untouched
      readBlock(IDX_EN_LOW, '{8'h00, 8'h0C, 8'h00, 8'h46, 8'hFF, 8'h35});
      $display("write test done");
   endtask
   task automatic testOverride();
      writeBlock(IDX_EN_LOW, '{8'hFF, 8'hFF});
      settle();
      oePinsN = 7'h05;
      settle();
      check("run", {1'b0, outRun}, 8'h7A);
      check("slew", {1'b0, outSlewFast}, 8'h00);
      check("amplitude", {6'h00, outAmplitude}, 8'h03);
      oePinsN = 7'h00;
      $display("override test done");
   endtask
   task automatic testAddress();
      addrSelLevel = SEL_MID;
      settle();
      check("address", {1'b0, targetAddr}, {1'b0, ADDR_LOW});
      scbp_host_model_inst.startCond();
      sendExp({ADDR_MID, 1'b0}, 1'b0);
      scbp_host_model_inst.stopCond();
      $display("address test done");
   endtask
   // bounded wait for the address latch after a reset release
   task automatic waitLock();
      for (int i = 0; i < 50 && addrLocked !== 1'b1; i++) @(negedge clk);
      check("locked", {7'h00, addrLocked}, 8'h01);
   endtask
   // mid-run reset with the select pin at mid level relatches the address
   task automatic testRelatch();
      @(negedge clk);
      sys_rst = 1'b1;
      addrSelLevel = SEL_MID;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      waitLock();
      check("address", {1'b0, targetAddr}, {1'b0, ADDR_MID});
      check("run", {1'b0, outRun}, 8'h7F);
      #1us;
      scbp_host_model_inst.startCond();
      sendExp({ADDR_LOW, 1'b0}, 1'b0);
      scbp_host_model_inst.startCond();
      sendExp({ADDR_MID, 1'b0}, 1'b1);
      scbp_host_model_inst.stopCond();
      $display("relatch test done");
   endtask
   // hang guard
   initial begin
      #2ms;
      err_count++;
      end_of_test();
   end
   initial begin
      sys_rst = 1'b1;
      oePinsN = 7'h00;
      addrSelLevel = SEL_LOW;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      waitLock();
      // without a latched address every link test would only pile up mismatches
      if (addrLocked === 1'b1) begin
         #1us;
         testReset();
         testWriteZero();
         testOverride();
         testAddress();
         testRelatch();
      end
      end_of_test();
   end
endmodule
